// ### hw/ific_pkg.sv
package ific_pkg;
	// =========================================
	// Sizes
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 8;

	// =========================================
	// Register offsets
	localparam logic [7:0] CTRL_OFF  = 8'h00;
	localparam logic [7:0] FL0_OFF   = 8'h08;
	localparam logic [7:0] EN0_OFF   = 8'h0C;
	localparam logic [7:0] FL1_OFF   = 8'h10;
	localparam logic [7:0] EN1_OFF   = 8'h14;
	localparam logic [7:0] LEN_OFF   = 8'h18;
	localparam logic [7:0] RXC0_OFF  = 8'h1C;
	localparam logic [7:0] RXC1_OFF  = 8'h20;
	localparam logic [7:0] TXC0_OFF  = 8'h24;
	localparam logic [7:0] TXC1_OFF  = 8'h28;
	localparam logic [7:0] DATA_OFF  = 8'h2C;

	// =========================================
	// Field positions
	localparam int THR_LSB        = 8;
	localparam int CNT_LSB        = 8;
	localparam int FLUSH_BIT      = 7;
	localparam int DNR_BIT        = 0;
	localparam int MST_BIT        = 0;
	localparam int READY_MODE_BIT = 1;
	localparam int PRELOAD_BIT    = 0;
	localparam int TX_LAST_BIT    = 1;
	localparam int TX_READY_BIT   = 0;
	localparam int LEN_TX_LSB     = 8;
	localparam int FL1_TXU_BIT    = 1;
	localparam int FL1_RXO_BIT    = 0;
	localparam int F_LOCKOUT = 15;
	localparam int F_SSTOP   = 14;
	localparam int F_SSTART  = 13;
	localparam int F_NOANS   = 12;
	localparam int F_DREF    = 11;
	localparam int F_AREF    = 10;
	localparam int F_TMO     = 9;
	localparam int F_ARB     = 8;
	localparam int F_AACK    = 7;
	localparam int F_STOP    = 6;
	localparam int F_TXTH    = 5;
	localparam int F_RXTH    = 4;
	localparam int F_AMATCH  = 3;
	localparam int F_GCALL   = 2;
	localparam int F_INTRX   = 1;
	localparam int F_DONE    = 0;

	// =========================================
	// Reset and fixed values
	localparam logic [7:0] RX_CNT_RST   = 8'h01;
	localparam logic       TX_READY_RST = 1'b1;
	localparam logic [7:0] EMPTY_BYTE   = 8'hFF;
	localparam logic [7:0] FIFO_LEN_VAL = 8'h08;
	localparam logic [8:0] RX_CNT_MAX   = 9'h100;

	typedef struct packed {
		logic stray_stop_error;
		logic stray_start_error;
		logic data_refused_error;
		logic address_refused_error;
		logic bus_hold_timeout_error;
		logic arbitration_loss_error;
		logic addr_ack;
		logic interactive_receive_mode;
		logic done;
	} ific_evt_t;

	typedef struct packed {
		logic [15:0]      en0;
		logic [15:0]      fl0;
		logic [1:0]       fl1;
		logic [1:0]       en1;
		logic [3:0]       rx_thr;
		logic             rx_flush;
		logic             dnr;
		logic [7:0]       rx_cnt;
		logic [3:0]       tx_thr;
		logic             tx_flush;
		logic             ready_mode;
		logic             preload;
		logic             tx_last;
		logic             tx_ready;
		logic             mst;
		logic [7:0][7:0]  rx_mem;
		logic [2:0]       rx_rd;
		logic [3:0]       rx_n;
		logic [7:0][7:0]  tx_mem;
		logic [2:0]       tx_rd;
		logic [3:0]       tx_n;
		logic [7:0]       tx_data;
		logic [31:0]      prdata;
		logic             pslverr;
		logic [1:0]       scl_s;
		logic [1:0]       sda_s;
		logic             scl_p;
		logic             sda_p;
		logic             hold;
		logic             refuse;
	} ific_state_t;
endpackage

// ### hw/ific_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ific_top
	import ific_pkg::*;
(
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RST,
	// APB slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [DATA_W-1:0] PWDATA,
	output logic      [DATA_W-1:0] PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// Two-wire pins
	input  wire logic              SCL_I,
	input  wire logic              SDA_I,
	output logic                   SCL_O,
	output logic                   SCL_OE,
	// Protocol engine, same clock
	input  wire ific_evt_t         ENG_EVT,
	input  wire logic              ENG_ADDR_MATCH,
	input  wire logic              ENG_GCALL_MATCH,
	input  wire logic              ENG_WRITE_REQ,
	input  wire logic              ENG_RX_VALID,
	input  wire logic [7:0]        ENG_RX_DATA,
	input  wire logic              ENG_TX_POP,
	output logic [7:0]             ENG_TX_DATA,
	output logic                   ADDR_ACK,
	output logic                   DATA_ACK,
	output logic [8:0]             MST_RX_COUNT,
	// Interrupt
	output logic                   IRQ
);

	// =========================================
	// Helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [15:0] fl0_view(input ific_state_t s);
		logic [15:0] v;
		v = s.fl0;
		v[F_TXTH] = (s.tx_n <= s.tx_thr);
		v[F_RXTH] = (s.rx_n >= s.rx_thr);
		fl0_view = v;
	endfunction

	ific_state_t q;
	ific_state_t d;

	logic        wr_acc;
	logic        rd_acc;
	logic        setup;
	logic        start_cond;
	logic        stop_cond;
	logic        slave;
	logic        match;
	logic        refuse_addr;
	logic        ready_block;
	logic        rx_store;
	logic [31:0] rd_word;

	assign setup  = PSEL & ~PENABLE;
	assign wr_acc = PSEL & PENABLE & PWRITE;
	assign rd_acc = PSEL & PENABLE & ~PWRITE;
	assign slave  = ~q.mst;
	assign match  = slave & (ENG_ADDR_MATCH | ENG_GCALL_MATCH);

	// Start: SDA falls with SCL high; stop: SDA rises with SCL high
	assign start_cond = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
	assign stop_cond  = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];

	// Preload without ready refuses the address; so does dnr with pending data on a write request
	assign ready_block = q.preload & ~q.tx_ready;
	assign refuse_addr = ready_block | (q.dnr & ENG_WRITE_REQ & (q.rx_n != 4'h0));
	assign rx_store    = ENG_RX_VALID & ~q.refuse;

	// =========================================
	// Read mux
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (PADDR)
			CTRL_OFF: rd_word[MST_BIT] = q.mst;
			FL0_OFF:  rd_word[15:0] = fl0_view(q);
			EN0_OFF:  rd_word[15:0] = q.en0;
			FL1_OFF:  rd_word[1:0] = q.fl1;
			EN1_OFF:  rd_word[1:0] = q.en1;
			LEN_OFF:  rd_word[15:0] = {FIFO_LEN_VAL, FIFO_LEN_VAL};
			RXC0_OFF: rd_word = {20'h0_0000, q.rx_thr, q.rx_flush, 6'h00, q.dnr};
			RXC1_OFF: rd_word = {20'h0_0000, q.rx_n, q.rx_cnt};
			TXC0_OFF: rd_word = {20'h0_0000, q.tx_thr, q.tx_flush, 5'h00, q.ready_mode, q.preload};
			TXC1_OFF: rd_word = {20'h0_0000, q.tx_n, 6'h00, q.tx_last, q.tx_ready};
			DATA_OFF: rd_word[7:0] = (q.rx_n == 4'h0) ? EMPTY_BYTE : q.rx_mem[q.rx_rd];
			default:  rd_word = 32'h0000_0000;
		endcase
	end

	// =========================================
	// Next state
	always_comb
	begin
		d = q;
		d.scl_s = {q.scl_s[0], SCL_I};
		d.sda_s = {q.sda_s[0], SDA_I};
		d.scl_p = q.scl_s[1];
		d.sda_p = q.sda_s[1];

		// Bus slave: zero wait, data sampled in setup
		if (setup)
		begin
			d.prdata  = rd_word;
			d.pslverr = ~(hit(PADDR, CTRL_OFF) | hit(PADDR, FL0_OFF) | hit(PADDR, EN0_OFF)
				| hit(PADDR, FL1_OFF) | hit(PADDR, EN1_OFF) | hit(PADDR, LEN_OFF)
				| hit(PADDR, RXC0_OFF) | hit(PADDR, RXC1_OFF) | hit(PADDR, TXC0_OFF)
				| hit(PADDR, TXC1_OFF) | hit(PADDR, DATA_OFF));
		end

		// Flushes complete one cycle after the request
		if (q.rx_flush)
		begin
			d.rx_n     = 4'h0;
			d.rx_flush = 1'b0;
		end
		if (q.tx_flush)
		begin
			d.tx_n     = 4'h0;
			d.tx_flush = 1'b0;
		end

		// Software writes
		if (wr_acc)
		begin
			if (hit(PADDR, CTRL_OFF))
				d.mst = PWDATA[MST_BIT];
			if (hit(PADDR, FL0_OFF))
				d.fl0 = q.fl0 & ~PWDATA[15:0];
			if (hit(PADDR, EN0_OFF))
				d.en0 = PWDATA[15:0];
			if (hit(PADDR, FL1_OFF))
				d.fl1 = q.fl1 & ~PWDATA[1:0];
			if (hit(PADDR, EN1_OFF))
				d.en1 = PWDATA[1:0];
			if (hit(PADDR, RXC0_OFF))
			begin
				d.rx_thr = PWDATA[THR_LSB+:4];
				d.dnr    = PWDATA[DNR_BIT];
				if (PWDATA[FLUSH_BIT])
					d.rx_flush = 1'b1;
			end
			if (hit(PADDR, RXC1_OFF))
				d.rx_cnt = PWDATA[7:0];
			if (hit(PADDR, TXC0_OFF))
			begin
				d.tx_thr     = PWDATA[THR_LSB+:4];
				d.ready_mode = PWDATA[READY_MODE_BIT];
				d.preload    = PWDATA[PRELOAD_BIT];
				if (PWDATA[FLUSH_BIT])
					d.tx_flush = 1'b1;
			end
			if (hit(PADDR, TXC1_OFF))
			begin
				if (PWDATA[TX_LAST_BIT])
					d.tx_last = 1'b1;
				if (PWDATA[TX_READY_BIT])
					d.tx_ready = 1'b1;
			end
			// Pushes dropped while full or locked out
			if (hit(PADDR, DATA_OFF) && q.tx_n != 4'(FIFO_DEPTH) && !q.fl0[F_LOCKOUT] && !q.tx_flush)
			begin
				d.tx_mem[3'(q.tx_rd + q.tx_n[2:0])] = PWDATA[7:0];
				d.tx_n = q.tx_n + 4'h1;
			end
		end
		if (rd_acc && hit(PADDR, DATA_OFF) && q.rx_n != 4'h0 && !q.rx_flush)
		begin
			d.rx_rd = q.rx_rd + 3'h1;
			d.rx_n  = d.rx_n - 4'h1;
		end

		// Engine events; set wins over a same-cycle clear
		d.fl0[F_SSTOP]  = d.fl0[F_SSTOP] | ENG_EVT.stray_stop_error;
		d.fl0[F_SSTART] = d.fl0[F_SSTART] | ENG_EVT.stray_start_error;
		d.fl0[F_DREF]   = d.fl0[F_DREF] | ENG_EVT.data_refused_error;
		d.fl0[F_AREF]   = d.fl0[F_AREF] | ENG_EVT.address_refused_error;
		d.fl0[F_TMO]    = d.fl0[F_TMO] | ENG_EVT.bus_hold_timeout_error;
		d.fl0[F_ARB]    = d.fl0[F_ARB] | ENG_EVT.arbitration_loss_error;
		d.fl0[F_AACK]   = d.fl0[F_AACK] | ENG_EVT.addr_ack;
		d.fl0[F_INTRX]  = d.fl0[F_INTRX] | ENG_EVT.interactive_receive_mode;
		d.fl0[F_DONE]   = d.fl0[F_DONE] | ENG_EVT.done;
		d.fl0[F_STOP]   = d.fl0[F_STOP] | (slave & stop_cond);
		d.fl0[F_TXTH]   = 1'b0;
		d.fl0[F_RXTH]   = 1'b0;

		// Address phase handling
		if (match)
		begin
			d.fl0[F_AMATCH] = d.fl0[F_AMATCH] | ENG_ADDR_MATCH;
			d.fl0[F_GCALL]  = d.fl0[F_GCALL] | ENG_GCALL_MATCH;
			if (refuse_addr)
				d.fl0[F_NOANS] = 1'b1;
			// Pending receive data with dnr clear: ack address, refuse data
			d.refuse = ENG_WRITE_REQ & ~q.dnr & (q.rx_n != 4'h0);
			if (!q.preload)
			begin
				d.tx_n           = 4'h0;
				d.fl0[F_LOCKOUT] = 1'b1;
			end
			else if (!q.ready_mode && q.tx_ready)
				d.tx_ready = 1'b0;
		end
		if (q.preload && !q.ready_mode && !q.tx_ready)
			d.tx_ready = d.tx_ready & ~(wr_acc & hit(PADDR, TXC0_OFF));
		if (!d.preload)
			d.tx_ready = 1'b1;

		// Received bytes
		if (rx_store)
		begin
			if (q.rx_n == 4'(FIFO_DEPTH))
				d.fl1[FL1_RXO_BIT] = slave | d.fl1[FL1_RXO_BIT];
			else if (!q.rx_flush)
			begin
				d.rx_mem[3'(q.rx_rd + q.rx_n[2:0])] = ENG_RX_DATA;
				d.rx_n = d.rx_n + 4'h1;
			end
		end

		// Transmit byte request after master ack
		if (ENG_TX_POP)
		begin
			if (q.tx_n == 4'h0)
			begin
				if (slave)
				begin
					d.fl1[FL1_TXU_BIT] = 1'b1;
					d.hold = ~q.tx_last;
				end
			end
			else if (!q.tx_flush && !match)
			begin
				d.tx_data = q.tx_mem[q.tx_rd];
				d.tx_rd   = q.tx_rd + 3'h1;
				d.tx_n    = d.tx_n - 4'h1;
			end
		end
		if (q.hold && (q.tx_n != 4'h0 || q.tx_last))
			d.hold = 1'b0;

		// Stop or repeated start ends the transfer
		if (start_cond || stop_cond)
		begin
			d.tx_last = 1'b0;
			d.hold    = 1'b0;
			d.refuse  = 1'b0;
		end
	end

	// =========================================
	// Registers
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
		begin
			q          <= '0;
			q.rx_cnt   <= RX_CNT_RST;
			q.tx_ready <= TX_READY_RST;
			q.scl_s    <= 2'b11;
			q.sda_s    <= 2'b11;
			q.scl_p    <= 1'b1;
			q.sda_p    <= 1'b1;
		end
		else
			q <= d;
	end

	// =========================================
	// Outputs
	assign PRDATA       = q.prdata;
	assign PREADY       = 1'b1;
	assign PSLVERR      = q.pslverr & PSEL & PENABLE;
	assign SCL_O        = 1'b0;
	assign SCL_OE       = q.hold;
	assign ENG_TX_DATA  = q.tx_data;
	assign ADDR_ACK     = ~refuse_addr;
	assign DATA_ACK     = ~q.refuse;
	assign MST_RX_COUNT = (q.rx_cnt == 8'h00) ? RX_CNT_MAX : {1'b0, q.rx_cnt};
	assign IRQ          = (|(fl0_view(q) & q.en0)) | (|(q.fl1 & q.en1));

	// =========================================
	// Checks
	irq_source_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(ENG_EVT.done && q.en0[F_DONE] && !(wr_acc && PADDR == EN0_OFF)) |=> IRQ)
		else $error("enabled flag gave no interrupt");
	rx_flush_done_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(wr_acc && PADDR == RXC0_OFF && PWDATA[FLUSH_BIT]) |=> q.rx_flush ##1 (!q.rx_flush && q.rx_n == 4'h0))
		else $error("receive flush did not finish");
	tx_underflow_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(ENG_TX_POP && slave && q.tx_n == 4'h0) |=> q.fl1[FL1_TXU_BIT])
		else $error("underflow not flagged");
	rx_overflow_set_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(rx_store && slave && q.rx_n == 4'h8 && !rd_acc && !q.rx_flush) |=> (q.fl1[FL1_RXO_BIT] && $stable(q.rx_n)))
		else $error("overflow not flagged");
	match_lock_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(match && !q.preload) |=> (q.fl0[F_LOCKOUT] && q.tx_n == 4'h0))
		else $error("match did not lock queue");
	preload_nolock_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(match && q.preload && !q.fl0[F_LOCKOUT] && !ENG_EVT.done) |=> !q.fl0[F_LOCKOUT])
		else $error("preload match locked queue");
	ready_forced_a: assert property (@(posedge REF_CLK) disable iff (RST)
		!q.preload |-> q.tx_ready)
		else $error("ready not forced");
	scl_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(ENG_TX_POP && slave && q.tx_n == 4'h0 && !q.tx_last && !start_cond && !stop_cond) |=> SCL_OE)
		else $error("scl not held on empty queue");
	rx_thresh_a: assert property (@(posedge REF_CLK) disable iff (RST)
		(setup && PADDR == FL0_OFF && q.rx_n >= q.rx_thr) |=> PRDATA[F_RXTH])
		else $error("receive threshold flag missing");

endmodule // ific_top
`default_nettype wire

// ### test/ific_peer.sv
`timescale 1ns/1ns
`default_nettype none
module ific_peer
	import ific_pkg::*;
(
	// Clock and answer
	input  wire logic       clk,
	input  wire logic       ack,
	// Engine side
	output ific_evt_t       evt,
	output logic            amatch,
	output logic            gmatch,
	output logic            wreq,
	output logic            rxv,
	output logic      [7:0] rxd,
	output logic            pop,
	// Pins, pulled up when idle
	output logic            scl,
	output logic            sda
);
	initial
	begin
		evt = '0;
		{amatch, gmatch, wreq, rxv, pop} = '0;
		rxd = 8'h00;
		{scl, sda} = 2'h3;
	end

	task automatic pulse(input int i);
		@(posedge clk);
		evt <= ific_evt_t'(9'h001 << i);
		@(posedge clk);
		evt <= '0;
	endtask

	task automatic rx(input logic [7:0] b);
		@(posedge clk);
		rxv <= 1'b1;
		rxd <= b;
		@(posedge clk);
		rxv <= 1'b0;
		rxd <= ~b;
	endtask

	task automatic take;
		@(posedge clk);
		pop <= 1'b1;
		@(posedge clk);
		pop <= 1'b0;
	endtask

	// Answer taken at the very edge that takes the match
	task automatic match(input logic g, input logic w, output logic a);
		@(posedge clk);
		amatch <= ~g;
		gmatch <= g;
		wreq <= w;
		@(posedge clk);
		a = ack;
		{amatch, gmatch} <= 2'h0;
	endtask

	// Start, one 320 ns clock, stop; clock still outside frames
	task automatic frame;
		@(posedge clk);
		sda <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		sda <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule // ific_peer
`default_nettype wire

// ### test/ific_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module ific_top_test;
	import ific_pkg::*;
	logic             clk, rst, psel, pen, pwr, er, a;
	logic      [7:0]  padr, b, rxd, txd;
	logic      [31:0] pwd, rd, prd, m;
	logic             rdy, slv, so, soe, am, gm, wq, rxv, pop;
	logic             aack, dack, irq, sclp, sdap;
	logic      [8:0]  mcnt;
	ific_evt_t        evt;
	int               err_total, compares, thr;
	logic      [7:0]  rxq[$], txq[$];
	int               fmap[9] = '{0, 1, 7, 8, 9, 10, 11, 13, 14};
	logic      [7:0]  ra[8] = '{EN0_OFF, FL1_OFF, EN1_OFF, LEN_OFF,
		RXC0_OFF, RXC1_OFF, TXC0_OFF, TXC1_OFF};
	logic      [31:0] rv[8] = '{32'h0, 32'h0, 32'h0, 32'h808, 32'h0, 32'h1, 32'h0, 32'h1};

	ific_top ific_top_i(.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(slv),
		.SCL_I(soe ? so : sclp), .SDA_I(sdap), .SCL_O(so), .SCL_OE(soe), .ENG_EVT(evt),
		.ENG_ADDR_MATCH(am), .ENG_GCALL_MATCH(gm), .ENG_WRITE_REQ(wq), .ENG_RX_VALID(rxv),
		.ENG_RX_DATA(rxd), .ENG_TX_POP(pop), .ENG_TX_DATA(txd), .ADDR_ACK(aack),
		.DATA_ACK(dack), .MST_RX_COUNT(mcnt), .IRQ(irq));
	ific_peer ific_peer_i(.clk(clk), .ack(aack), .evt(evt), .amatch(am), .gmatch(gm),
		.wreq(wq), .rxv(rxv), .rxd(rxd), .pop(pop), .scl(sclp), .sda(sdap));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Zero-wait slave, but the wait loop does not rely on it
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= ad;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		rd = prd;
		er = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	initial
	begin
		#3000000;
		err_total++;
		stop_test();
	end

	// =========================================
	// Tests
	initial
	begin
		{psel, pen, pwr, padr, pwd} = '0;
		rst = 1'b1;
		void'($urandom(99507));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset", rd, rv[i]);
		end
		chk("mst_cnt", 32'(mcnt), 32'h1);
		chk("dack_rst", 32'(dack), 32'h1);
		apb(1'b0, 8'hFC, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		$display("reset test done");

		for (int i = 0; i < 9; i++)
		begin
			m = 32'h1 << fmap[i];
			apb(1'b1, EN0_OFF, m);
			chk("irq_idle", 32'(irq), 32'h0);
			ific_peer_i.pulse(i);
			apb(1'b0, FL0_OFF, 32'h0);
			chk("flag", rd & m, m);
			chk("irq_set", 32'(irq), 32'h1);
			apb(1'b1, FL0_OFF, m);
			@(posedge clk);
			chk("irq_clr", 32'(irq), 32'h0);
		end
		apb(1'b1, EN0_OFF, 32'h0);
		$display("event test done");

		thr = $urandom_range(8, 1);
		apb(1'b1, RXC0_OFF, 32'(thr) << 8);
		for (int i = 0; i < 9; i++)
		begin
			b = 8'($urandom);
			ific_peer_i.rx(b);
			if (rxq.size() < 8)
				rxq.push_back(b);
			apb(1'b0, RXC1_OFF, 32'h0);
			chk("rx_count", 32'(rd[11:8]), rxq.size());
			apb(1'b0, FL0_OFF, 32'h0);
			chk("rx_thr", 32'(rd[4]), 32'(rxq.size() >= thr));
		end
		apb(1'b1, FL1_OFF, 32'h0);
		apb(1'b1, EN1_OFF, 32'h1);
		apb(1'b0, FL1_OFF, 32'h0);
		chk("ovf", rd, 32'h1);
		chk("ovf_irq", 32'(irq), 32'h1);
		apb(1'b1, FL1_OFF, 32'h1);
		apb(1'b0, FL1_OFF, 32'h0);
		chk("ovf_clr", rd, 32'h0);
		apb(1'b1, EN1_OFF, 32'h0);
		apb(1'b0, DATA_OFF, 32'h0);
		chk("rx_data", 32'(rd[7:0]), 32'(rxq.pop_front()));
		ific_peer_i.match(1'b0, 1'b1, a);
		chk("ack_dnr0", 32'(a), 32'h1);
		@(posedge clk);
		chk("dack", 32'(dack), 32'h0);
		ific_peer_i.rx(8'h5A);
		apb(1'b0, RXC1_OFF, 32'h0);
		chk("rx_refused", 32'(rd[11:8]), rxq.size());
		apb(1'b1, RXC0_OFF, 32'h1);
		ific_peer_i.match(1'b0, 1'b1, a);
		chk("ack_dnr1", 32'(a), 32'h0);
		apb(1'b1, RXC0_OFF, 32'h80);
		rxq.delete();
		apb(1'b0, RXC1_OFF, 32'h0);
		chk("rx_flush", rd & 32'hF00, 32'h0);
		apb(1'b0, RXC0_OFF, 32'h0);
		chk("flush_bit", rd, 32'h0);
		m = $urandom_range(255, 1);
		for (int v = 0; v < 2; v++)
		begin
			apb(1'b1, RXC1_OFF, v ? m : 32'h0);
			@(posedge clk);
			chk("mst_cnt", 32'(mcnt), v ? m : 32'h100);
		end
		$display("receive test done");

		apb(1'b1, FL0_OFF, 32'hFFFF);
		ific_peer_i.frame();
		thr = $urandom_range(7, 1);
		apb(1'b1, TXC0_OFF, 32'(thr) << 8);
		for (int i = 0; i < 9; i++)
		begin
			b = 8'($urandom);
			apb(1'b1, DATA_OFF, 32'(b));
			if (txq.size() < 8)
				txq.push_back(b);
			apb(1'b0, TXC1_OFF, 32'h0);
			chk("tx_count", 32'(rd[11:8]), txq.size());
			apb(1'b0, FL0_OFF, 32'h0);
			chk("tx_thr", 32'(rd[5]), 32'(txq.size() <= thr));
		end
		for (int i = 0; i < 9; i++)
		begin
			ific_peer_i.take();
			@(negedge clk);
			if (i < 8)
				chk("tx_data", 32'(txd), 32'(txq.pop_front()));
		end
		@(negedge clk);
		chk("hold_scl", 32'(soe), 32'h1);
		apb(1'b0, FL1_OFF, 32'h0);
		chk("underflow", rd, 32'h2);
		apb(1'b1, TXC1_OFF, 32'h2);
		repeat (2) @(posedge clk);
		chk("release", 32'(soe), 32'h0);
		ific_peer_i.frame();
		apb(1'b0, TXC1_OFF, 32'h0);
		chk("last_clr", rd, 32'h1);
		apb(1'b1, FL1_OFF, 32'h2);
		apb(1'b1, DATA_OFF, 32'h11);
		apb(1'b1, TXC0_OFF, 32'h80);
		apb(1'b0, TXC1_OFF, 32'h0);
		chk("tx_flush", rd, 32'h1);
		apb(1'b1, DATA_OFF, 32'h22);
		ific_peer_i.match(1'b1, 1'b0, a);
		apb(1'b1, DATA_OFF, 32'h33);
		apb(1'b0, TXC1_OFF, 32'h0);
		chk("locked", rd, 32'h1);
		apb(1'b0, FL0_OFF, 32'h0);
		chk("lockout", rd & 32'h8000, 32'h8000);
		apb(1'b1, FL0_OFF, 32'hFFFF);
		apb(1'b1, TXC0_OFF, 32'h1);
		for (int i = 0; i < 3; i++)
		begin
			if (i == 2)
				apb(1'b1, TXC1_OFF, 32'h1);
			ific_peer_i.match(1'b0, 1'b0, a);
			chk("preload_ack", 32'(a), 32'(i != 1));
		end
		apb(1'b0, FL0_OFF, 32'h0);
		chk("no_lock", rd & 32'h8000, 32'h0);
		apb(1'b1, TXC0_OFF, 32'h3);
		apb(1'b1, TXC1_OFF, 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			ific_peer_i.match(1'b0, 1'b0, a);
			chk("manual_ack", 32'(a), 32'h1);
		end
		apb(1'b1, TXC0_OFF, 32'h0);
		apb(1'b0, TXC1_OFF, 32'h0);
		chk("ready_forced", rd & 32'h1, 32'h1);
		$display("transmit test done");
		stop_test();
	end
endmodule // ific_top_test
`default_nettype wire
